// file: rtl/adcpc_top.sv
/*
 Power, stabilizer and output-mode control of a quad serial converter: power state machine,
 configuration registers, stabilizer lock tracking, output coding and the serial output stage.
 Assumes synchronous inputs, a single-cycle register port and a clock
 monitor that flags sample rates under 20 MHz and rate changes.
*/
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/1ps
`include "adcpc_regs.svh"
module adcpc_top
import adcpc_pkg::*;
#(
    parameter int NCH = 4,
    parameter int W = 8,
    parameter int PD_WAKE_CYC = `ADCPC_PD_WAKE_CYC
)
(
    input wire logic clk_sys_in,                   // 40 MHz system clock
    input wire logic arst_n_in,                    // Asynchronous reset, active low
    input wire logic power_down_pin_in,            // Full power-down request
    input wire logic serial_io_output_mode_pin_in, // Low-swing strap
    input wire logic clk_rate_ok_in,               // Sample clock at or above 20 MHz
    input wire logic clk_rate_change_in,           // Sample clock rate changed
    input wire logic [NCH-1:0][W-1:0] samples_in,  // Converted samples
    input wire logic [3:0] addr_in,                // Register address
    input wire logic [15:0] wdata_in,              // Register write data
    input wire logic wr_in,                        // Write strobe
    input wire logic rd_in,                        // Read strobe
    output logic [15:0] rdata_out,                 // Read data, cycle after strobe
    output logic [NCH-1:0] lane_out,               // Serial data lanes
    output logic [NCH-1:0] lane_oe_out,            // Lane driver enables
    output logic fco_out,                          // Frame clock
    output logic fco_oe_out,                       // Frame clock driver enable
    output logic dco_out,                          // Bit clock
    output logic dco_oe_out,                       // Bit clock driver enable
    output logic [NCH-1:0] chan_pwr_out,           // Channel core powered
    output adcpc_ana_t ana_out,                    // Analog block enables
    output logic low_swing_out,                    // Reduced swing drivers
    output logic term_boost_out,                   // Raised termination current
    output logic dcs_active_out                    // Stabilizer retiming the clock
);
    localparam int CW = $clog2(((PD_WAKE_CYC > `ADCPC_STBY_WAKE_CYC) ? PD_WAKE_CYC : `ADCPC_STBY_WAKE_CYC) + 1);
    localparam int RW = $clog2(`ADCPC_RELOCK_CYC + 1);
    localparam logic [CW-1:0] STBY_CYC = CW'(`ADCPC_STBY_WAKE_CYC);
    localparam logic [CW-1:0] PD_CYC = CW'(PD_WAKE_CYC);
    localparam logic [RW-1:0] RELOCK_CYC = RW'(`ADCPC_RELOCK_CYC);

    adcpc_pwr_t state_r;
    adcpc_cfg_t cfg_r;
    logic pd_s1_r;
    logic pd_s2_r;
    logic [CW-1:0] pd_cnt_r;
    logic [CW-1:0] wake_cnt_r;
    logic strap_done_r;
    logic strap_r;
    logic [RW-1:0] lock_cnt_r;
    logic dcs_locked_r;
    logic ser_run;
    logic [NCH-1:0][W-1:0] words;

    function automatic logic [W-1:0] code_word(input logic [W-1:0] s, input logic twos);
        code_word = twos ? {~s[W-1], s[W-2:0]} : s;
    endfunction

    // Pin synchroniser
    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            pd_s1_r <= 1'b0;
            pd_s2_r <= 1'b0;
        end
        else
        begin
            pd_s1_r <= power_down_pin_in; // RULE18
            pd_s2_r <= pd_s1_r; // RULE18
        end
    end

    // Power state machine
    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            state_r <= PWR_ACTIVE;
            wake_cnt_r <= '0;
        end
        else
        begin
            unique case (state_r)
                PWR_ACTIVE:
                    if (pd_s2_r)
                        state_r <= PWR_DOWN; // RULE1
                    else if (cfg_r.standby)
                        state_r <= PWR_STANDBY; // RULE8
                PWR_STANDBY:
                    if (pd_s2_r)
                        state_r <= PWR_DOWN; // RULE1
                    else if (!cfg_r.standby)
                    begin
                        state_r <= PWR_WAKE;
                        wake_cnt_r <= STBY_CYC; // RULE8
                    end
                PWR_DOWN:
                    if (!pd_s2_r)
                    begin
                        // Wake time follows time spent down
                        state_r <= PWR_WAKE; // RULE4
                        wake_cnt_r <= (pd_cnt_r == '0) ? CW'(1) : pd_cnt_r;
                    end
                PWR_WAKE:
                    if (pd_s2_r)
                        state_r <= PWR_DOWN; // RULE1
                    else if (wake_cnt_r <= CW'(1))
                        state_r <= PWR_ACTIVE;
                    else
                        wake_cnt_r <= wake_cnt_r - 1'b1;
            endcase
        end
    end

    // Saturating count of time spent in full power-down
    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            pd_cnt_r <= '0;
        else if (state_r != PWR_DOWN)
            pd_cnt_r <= '0;
        else if (pd_cnt_r < PD_CYC)
            pd_cnt_r <= pd_cnt_r + 1'b1;
    end

    // Configuration registers, untouched by power state
    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            cfg_r.twos_comp <= 1'((`ADCPC_CTRL_RESET >> `ADCPC_CTRL_TWOS_COMP) & 16'h0001);
            cfg_r.term_boost <= 1'((`ADCPC_CTRL_RESET >> `ADCPC_CTRL_TERM_BOOST) & 16'h0001);
            cfg_r.low_swing <= 1'((`ADCPC_CTRL_RESET >> `ADCPC_CTRL_LOW_SWING) & 16'h0001);
            cfg_r.dcs_en <= 1'((`ADCPC_CTRL_RESET >> `ADCPC_CTRL_DCS_EN) & 16'h0001); // RULE13
            cfg_r.standby <= 1'((`ADCPC_CTRL_RESET >> `ADCPC_CTRL_STANDBY) & 16'h0001);
            cfg_r.ch_pd <= 4'(`ADCPC_CHPD_RESET);
        end
        else if (wr_in && addr_in == `ADCPC_ADDR_CTRL) // RULE3
        begin
            cfg_r.twos_comp <= wdata_in[`ADCPC_CTRL_TWOS_COMP]; // RULE16
            cfg_r.term_boost <= wdata_in[`ADCPC_CTRL_TERM_BOOST]; // RULE15
            cfg_r.low_swing <= wdata_in[`ADCPC_CTRL_LOW_SWING]; // RULE14
            cfg_r.dcs_en <= wdata_in[`ADCPC_CTRL_DCS_EN]; // RULE9
            cfg_r.standby <= wdata_in[`ADCPC_CTRL_STANDBY]; // RULE8
        end
        else if (wr_in && addr_in == `ADCPC_ADDR_CHPD)
            cfg_r.ch_pd <= wdata_in[3:0]; // RULE7
    end

    // Strap caught once after reset release
    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            strap_done_r <= 1'b0;
        else
            strap_done_r <= 1'b1;
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!strap_done_r)
            strap_r <= serial_io_output_mode_pin_in; // RULE14
    end

    // Stabilizer lock tracking
    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            lock_cnt_r <= '0;
            dcs_locked_r <= 1'b0;
        end
        else if (!clk_rate_ok_in || clk_rate_change_in || !cfg_r.dcs_en || !ana_out.pll_en)
        begin
            lock_cnt_r <= '0; // RULE10
            dcs_locked_r <= 1'b0;
        end
        else if (lock_cnt_r < RELOCK_CYC)
            lock_cnt_r <= lock_cnt_r + 1'b1;
        else
            dcs_locked_r <= 1'b1;
    end

    // Unlocked loop falls back to the raw clock
    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            dcs_active_out <= 1'b0;
        else
            dcs_active_out <= cfg_r.dcs_en && dcs_locked_r && clk_rate_ok_in; // RULE12 RULE9
    end

    // Analog enables and output drivers
    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            ana_out <= '1;
            lane_oe_out <= '0;
            fco_oe_out <= 1'b0;
            dco_oe_out <= 1'b0;
            chan_pwr_out <= '0;
        end
        else
        begin
            ana_out.pll_en <= (state_r != PWR_DOWN); // RULE5 RULE8
            ana_out.ref_en <= ser_run; // RULE5
            ana_out.refbuf_en <= ser_run; // RULE5
            ana_out.bias_en <= ser_run; // RULE5
            lane_oe_out <= ser_run ? ~cfg_r.ch_pd : '0; // RULE2 RULE7
            fco_oe_out <= ser_run; // RULE2
            dco_oe_out <= ser_run; // RULE2
            chan_pwr_out <= ser_run ? ~cfg_r.ch_pd : '0; // RULE7
        end
    end

    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            low_swing_out <= 1'b0;
            term_boost_out <= 1'b0;
        end
        else
        begin
            low_swing_out <= cfg_r.low_swing || (strap_done_r && strap_r); // RULE14
            term_boost_out <= cfg_r.term_boost; // RULE15
        end
    end

    // Register read port
    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            rdata_out <= '0;
        else if (!rd_in)
            rdata_out <= '0;
        else
            unique case (addr_in)
                `ADCPC_ADDR_CTRL:
                    rdata_out <= 16'({cfg_r.twos_comp, cfg_r.term_boost, cfg_r.low_swing,
                                      cfg_r.dcs_en, cfg_r.standby});
                `ADCPC_ADDR_CHPD:
                    rdata_out <= 16'(cfg_r.ch_pd);
                `ADCPC_ADDR_STAT:
                    rdata_out <= 16'({strap_r && strap_done_r, pd_s2_r, dcs_active_out, dcs_locked_r,
                                      state_r == PWR_ACTIVE, state_r});
                default:
                    rdata_out <= '0;
            endcase
    end

    assign ser_run = (state_r == PWR_ACTIVE) || (state_r == PWR_WAKE);

    always_comb
    begin
        for (int i = 0; i < NCH; i++)
            words[i] = code_word(samples_in[i], cfg_r.twos_comp); // RULE16
    end

    adcpc_serializer #(.NCH(NCH), .W(W)) u_ser (
        .clk_sys_in(clk_sys_in),
        .arst_n_in(arst_n_in),
        .run_in(ser_run),
        .words_in(words),
        .lane_out(lane_out),
        .fco_out(fco_out),
        .dco_out(dco_out),
        .load_out()
    );

    property p_pd_enter;
        @(posedge clk_sys_in) disable iff (!arst_n_in)
        $rose(pd_s2_r) |=> state_r == PWR_DOWN;
    endproperty
    a_pd_enter: assert property (p_pd_enter) else $error("power-down not entered"); // RULE1

    property p_pin_sync;
        @(posedge clk_sys_in) disable iff (!arst_n_in)
        $rose(power_down_pin_in) ##1 power_down_pin_in[*2] |=> state_r == PWR_DOWN;
    endproperty
    a_pin_sync: assert property (p_pin_sync) else $error("pin latency wrong"); // RULE18

    property p_tristate;
        @(posedge clk_sys_in) disable iff (!arst_n_in)
        state_r == PWR_DOWN |=> lane_oe_out == '0 && !fco_oe_out && !dco_oe_out;
    endproperty
    a_tristate: assert property (p_tristate) else $error("drivers on in power-down"); // RULE2

    property p_keep_cfg;
        @(posedge clk_sys_in) disable iff (!arst_n_in)
        state_r == PWR_DOWN && !wr_in |=> cfg_r == $past(cfg_r);
    endproperty
    a_keep_cfg: assert property (p_keep_cfg) else $error("config lost in power-down"); // RULE3

    property p_leave_pd;
        @(posedge clk_sys_in) disable iff (!arst_n_in)
        (state_r == PWR_DOWN || state_r == PWR_WAKE) && !pd_s2_r |=> state_r == PWR_ACTIVE && $past(state_r) == PWR_WAKE
            || state_r == PWR_WAKE && wake_cnt_r <= ($past(state_r) == PWR_DOWN ? PD_CYC : $past(wake_cnt_r) - 1'b1);
    endproperty
    a_leave_pd: assert property (p_leave_pd) else $error("no return from power-down"); // RULE4

    property p_ana_off;
        @(posedge clk_sys_in) disable iff (!arst_n_in)
        state_r == PWR_DOWN |=> ana_out == '0;
    endproperty
    a_ana_off: assert property (p_ana_off) else $error("analog on in power-down"); // RULE5

    property p_ch_pd;
        @(posedge clk_sys_in) disable iff (!arst_n_in)
        1'b1 |=> (lane_oe_out & $past(cfg_r.ch_pd)) == '0;
    endproperty
    a_ch_pd: assert property (p_ch_pd) else $error("powered-down lane driven"); // RULE7

    property p_standby;
        @(posedge clk_sys_in) disable iff (!arst_n_in)
        state_r == PWR_STANDBY && !cfg_r.standby && !pd_s2_r
        |=> state_r == PWR_WAKE ##23 state_r == PWR_WAKE ##1 state_r == PWR_ACTIVE || pd_s2_r;
    endproperty
    a_standby: assert property (p_standby) else $error("standby wake time wrong"); // RULE8

    property p_bypass;
        @(posedge clk_sys_in) disable iff (!arst_n_in)
        !dcs_locked_r || !cfg_r.dcs_en |=> !dcs_active_out;
    endproperty
    a_bypass: assert property (p_bypass) else $error("stabilizer used while unlocked"); // RULE12

    property p_frame;
        @(posedge clk_sys_in) disable iff (!arst_n_in)
        $rose(fco_out) && ser_run ##1 ser_run[*8] |-> $rose(fco_out);
    endproperty
    a_frame: assert property (p_frame) else $error("frame period wrong"); // RULE17
endmodule

// file: rtl/adcpc_regs.svh
/*
 Register offsets, field positions, reset values and timing counts of the
 converter power and output-mode control block.
 Assumes a 40 MHz system clock; included by bare name.
*/
// How it works
// (RULE1) Power-down pin high enters full power-down
// (RULE2) Full power-down tristates every serial output driver
// (RULE3) Configuration survives power-down without reset
// (RULE4) Pin low returns device to conversion
// (RULE5) Power-down disables reference, buffer, PLL, bias
// (RULE6) Host waits about 375 us after power-down
// (RULE7) Each channel can be powered down alone
// (RULE8) Standby keeps PLL running, wakes in 600 ns
// (RULE9) Stabilizer gives 50% duty, switchable off
// (RULE10) Stabilizer loop inactive below about 20 MHz
// (RULE11) Host allows 1.5-5 us for relock
// (RULE12) Unlocked stabilizer is bypassed, raw clock used
// (RULE13) Keep stabilizer on unless clock rate varies
// (RULE14) Default standard swing; low swing by strap/register
// (RULE15) Register raises termination current on all outputs
// (RULE16) Offset binary default, two's complement selectable
// (RULE17) Frame clock per word, bit clock four times
// (RULE18) Synchronise power-down pin before state machine
`ifndef ADCPC_REGS_SVH
`define ADCPC_REGS_SVH

`define ADCPC_ADDR_CTRL 4'h0
`define ADCPC_ADDR_CHPD 4'h1
`define ADCPC_ADDR_STAT 4'h2

`define ADCPC_CTRL_STANDBY 0
`define ADCPC_CTRL_DCS_EN 1
`define ADCPC_CTRL_LOW_SWING 2
`define ADCPC_CTRL_TERM_BOOST 3
`define ADCPC_CTRL_TWOS_COMP 4

`define ADCPC_STAT_STATE_LSB 0
`define ADCPC_STAT_READY 2
`define ADCPC_STAT_DCS_LOCKED 3
`define ADCPC_STAT_DCS_ACTIVE 4
`define ADCPC_STAT_POWER_DOWN_PIN 5
`define ADCPC_STAT_STRAP 6

`define ADCPC_CTRL_RESET 16'h0002
`define ADCPC_CHPD_RESET 16'h0000

`define ADCPC_CLK_NS 25
`define ADCPC_STBY_WAKE_NS 600
`define ADCPC_STBY_WAKE_CYC ((`ADCPC_STBY_WAKE_NS + `ADCPC_CLK_NS - 1) / `ADCPC_CLK_NS)
`define ADCPC_RELOCK_NS 1500
`define ADCPC_RELOCK_CYC ((`ADCPC_RELOCK_NS + `ADCPC_CLK_NS - 1) / `ADCPC_CLK_NS)
`define ADCPC_PD_WAKE_US 375
`define ADCPC_PD_WAKE_CYC ((`ADCPC_PD_WAKE_US * 1000) / `ADCPC_CLK_NS)

`endif

// file: rtl/adcpc_pkg.sv
/*
 Types of the converter power and output-mode control block.
 Assumes nothing of its surroundings.
*/
package adcpc_pkg;

    typedef enum logic [1:0] {PWR_ACTIVE, PWR_STANDBY, PWR_DOWN, PWR_WAKE} adcpc_pwr_t;

    typedef struct packed {
        logic twos_comp;
        logic term_boost;
        logic low_swing;
        logic dcs_en;
        logic standby;
        logic [3:0] ch_pd;
    } adcpc_cfg_t;

    typedef struct packed {
        logic ref_en;
        logic refbuf_en;
        logic pll_en;
        logic bias_en;
    } adcpc_ana_t;

endpackage

// file: rtl/adcpc_serializer.sv
/*
 Serialises one word per channel, MSB first, one bit per clock, with a
 frame clock per word and a double-data-rate bit clock.
 Assumes W is a power of two; words are sampled in the cycle the counter is zero.
*/
`timescale 1ns/1ps
module adcpc_serializer
#(
    parameter int NCH = 4,
    parameter int W = 8
)
(
    input wire logic clk_sys_in,                // System clock
    input wire logic arst_n_in,                 // Asynchronous reset, active low
    input wire logic run_in,                    // Serialiser running
    input wire logic [NCH-1:0][W-1:0] words_in, // Words to send
    output logic [NCH-1:0] lane_out,            // Serial data lanes
    output logic fco_out,                       // Frame clock
    output logic dco_out,                       // Bit clock
    output logic load_out                       // Word taken in the previous cycle
);
    localparam int CW = $clog2(W);

    logic [CW-1:0] cnt_r;
    logic [NCH-1:0][W-1:0] sh_r;

    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            cnt_r <= '0;
            fco_out <= 1'b0;
            dco_out <= 1'b0;
            load_out <= 1'b0;
        end
        else if (!run_in)
        begin
            cnt_r <= '0;
            fco_out <= 1'b0;
            dco_out <= 1'b0;
            load_out <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_r + 1'b1;
            // Frame high for the first half word, bit clock halves each bit pair
            fco_out <= (cnt_r < CW'(W / 2)); // RULE17
            dco_out <= ~dco_out; // RULE17
            load_out <= (cnt_r == '0);
        end
    end

    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            sh_r <= '0;
        else if (!run_in)
            sh_r <= '0;
        else if (cnt_r == '0)
            sh_r <= words_in;
        else
            for (int i = 0; i < NCH; i++)
                sh_r[i] <= {sh_r[i][W-2:0], 1'b0};
    end

    always_comb
    begin
        for (int i = 0; i < NCH; i++)
            lane_out[i] = sh_r[i][W-1];
    end
endmodule

// file: dv/adcpc_rx_model.sv
/*
 Receiver model of the serial outputs: frames words on the frame clock
 and counts stalls of the bit clock.
 Assumes registered outputs of the control block on the same clock.
*/
`timescale 1ns/1ps
module adcpc_rx_model
(
    input wire logic clk_in,           // System clock
    input wire logic [3:0] lane_in,    // Serial lanes
    input wire logic fco_in,           // Frame clock
    input wire logic fco_oe_in,        // Frame clock enable
    input wire logic dco_in,           // Bit clock
    input wire logic dco_oe_in,        // Bit clock enable
    output logic [3:0][7:0] word_out,  // Last word per lane
    output logic valid_out,            // New words, one cycle
    output int dco_err_out             // Bit clock stalls seen
);
    logic fco_q;
    logic dco_q;
    logic [3:0][7:0] sh;
    int cnt;
    int run;

    initial
    begin
        fco_q = 1'b0;
        dco_q = 1'b0;
        cnt = 8;
        run = 0;
        valid_out = 1'b0;
        word_out = '0;
        dco_err_out = 0;
    end

    always @(posedge clk_in)
    begin
        valid_out <= 1'b0;
        run = (fco_oe_in === 1'b1 && dco_oe_in === 1'b1) ? run + 1 : 0;
        if (run > 2 && dco_in === dco_q)
            dco_err_out <= dco_err_out + 1;
        if (run == 0)
            cnt = 8;
        else if (fco_in === 1'b1 && fco_q !== 1'b1)
            cnt = 0;
        if (cnt < 8)
        begin
            for (int c = 0; c < 4; c++)
                sh[c] = {sh[c][6:0], lane_in[c]};
            cnt++;
            if (cnt == 8)
            begin
                word_out <= sh;
                valid_out <= 1'b1;
            end
        end
        fco_q = fco_in;
        dco_q = dco_in;
    end
endmodule

// file: dv/test_adc_power_and_output_mode_control.sv
/*
 Self-checking bench of the power and output-mode control block.
 Assumes the receiver model on the serial side and a 40 MHz clock.
*/
`timescale 1ns/1ps
module test_adc_power_and_output_mode_control;
    import adcpc_pkg::*;
    logic clk_sys_in = 1'b0, arst_n_in = 1'b0, pd = 1'b0, strap = 1'b0, rate_ok = 1'b1, rate_chg = 1'b0;
    logic wr = 1'b0, rd = 1'b0;
    logic [3:0][7:0] samples = '0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000, rdata, v;
    logic [3:0] lane, lane_oe, chan_pwr, pwr_exp;
    logic frame_clock_out, fco_oe, bit_clock_out, dco_oe, low_swing, term_boost, dcs_active, rx_valid;
    adcpc_ana_t ana;
    logic [3:0][7:0] rx_word;
    logic [31:0] seed = 32'hecd6d083;
    int rx_dco_err, n_errors = 0, n_compared = 0, n, i;
    int exp_q[$];

    adcpc_top #(.NCH(4), .W(8), .PD_WAKE_CYC(20)) i_dut (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
        .power_down_pin_in(pd), .serial_io_output_mode_pin_in(strap), .clk_rate_ok_in(rate_ok),
        .clk_rate_change_in(rate_chg), .samples_in(samples), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
        .rd_in(rd), .rdata_out(rdata), .lane_out(lane), .lane_oe_out(lane_oe), .fco_out(frame_clock_out),
        .fco_oe_out(fco_oe), .dco_out(bit_clock_out), .dco_oe_out(dco_oe), .chan_pwr_out(chan_pwr), .ana_out(ana),
        .low_swing_out(low_swing), .term_boost_out(term_boost), .dcs_active_out(dcs_active));

    adcpc_rx_model i_rx (.clk_in(clk_sys_in), .lane_in(lane), .fco_in(frame_clock_out), .fco_oe_in(fco_oe), .dco_in(bit_clock_out),
        .dco_oe_in(dco_oe), .word_out(rx_word), .valid_out(rx_valid), .dco_err_out(rx_dco_err));

    initial
    begin
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
            n_errors++;
        end
    endtask

    task automatic end_of_test();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic do_reset();
        @(posedge clk_sys_in);
        arst_n_in <= 1'b0;
        repeat (4) @(posedge clk_sys_in);
        arst_n_in <= 1'b1;
    endtask

    task automatic wreg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys_in);
        wr <= 1'b0;
    endtask

    task automatic rreg(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_sys_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys_in);
        rd <= 1'b0;
        @(negedge clk_sys_in);
        d = rdata;
    endtask

    task automatic wait_fco_oe(input logic lvl);
        int k;
        for (k = 0; k < 50 && fco_oe !== lvl; k++)
            @(negedge clk_sys_in);
        chk("fco_oe wait", 16'(lvl), 16'(fco_oe));
    endtask

    task automatic wait_ready(output int cyc);
        logic [15:0] s;
        cyc = 0;
        s = 16'h0000;
        while (s[2] !== 1'b1 && cyc < 400)
        begin
            rreg(4'h2, s);
            cyc += 2;
        end
        chk("ready wait", 16'h0001, 16'(s[2]));
    endtask

    // Fresh random samples, then the third frame after them is compared
    task automatic data_check(input logic tc);
        int k, c;
        @(posedge clk_sys_in);
        seed = xs(seed);
        samples <= seed;
        for (c = 0; c < 4; c++)
            exp_q.push_back(int'(seed[c*8 +: 8] ^ (tc ? 8'h80 : 8'h00)));
        k = 0;
        for (c = 0; c < 200 && k < 3; c++)
        begin
            @(negedge clk_sys_in);
            if (rx_valid === 1'b1)
                k++;
        end
        chk("frames seen", 16'h0003, 16'(k));
        for (c = 0; c < 4; c++)
            chk("lane word", 16'(exp_q.pop_front()), 16'(rx_word[c]));
    endtask

    initial
    begin
        repeat (100000) @(posedge clk_sys_in);
        n_errors++;
        end_of_test();
    end

    initial
    begin
        do_reset();
        rreg(4'h0, v);
        chk("ctrl reset", 16'h0002, v);
        rreg(4'h1, v);
        chk("chpd reset", 16'h0000, v);
        rreg(4'h7, v);
        chk("unmapped read", 16'h0000, v);
        chk("low swing default", 16'h0000, 16'(low_swing));
        for (i = 0; i < 3; i++)
            data_check(1'b0);
        chk("bit clock stalls", 16'h0000, 16'(rx_dco_err));
        for (i = 0; i < 4; i++)
        begin
            wreg(4'h1, 16'(1 << i));
            repeat (2) @(negedge clk_sys_in);
            pwr_exp = ~(4'h1 << i);
            chk("channel power", 16'(pwr_exp), 16'(chan_pwr));
        end
        wreg(4'h1, 16'h0000);
        wreg(4'h0, 16'h0006);
        repeat (2) @(negedge clk_sys_in);
        chk("low swing", 16'h0001, 16'(low_swing));
        wreg(4'h0, 16'h000a);
        repeat (2) @(negedge clk_sys_in);
        chk("term boost", 16'h0002, {14'h0000, term_boost, low_swing});
        wreg(4'h0, 16'h0002);
        @(posedge clk_sys_in);
        pd <= 1'b1;
        repeat (4) @(negedge clk_sys_in);
        chk("pin synchroniser", 16'h0001, 16'(fco_oe));
        wait_fco_oe(1'b0);
        chk("drivers off", 16'h0000, {12'h000, lane_oe, fco_oe, dco_oe});
        chk("analog off", 16'h0000, 16'(ana));
        rreg(4'h2, v);
        chk("state down", 16'h0002, 16'(v[1:0]));
        wreg(4'h1, 16'h0005);
        wreg(4'h0, 16'h0012);
        @(posedge clk_sys_in);
        pd <= 1'b0;
        wait_fco_oe(1'b1);
        wait_ready(n);
        rreg(4'h0, v);
        chk("ctrl kept", 16'h0012, v);
        chk("chpd kept", 16'h000a, 16'(chan_pwr));
        chk("analog on", 16'h000f, 16'(ana));
        wreg(4'h1, 16'h0000);
        data_check(1'b1);
        wreg(4'h0, 16'h0002);
        data_check(1'b0);
        wreg(4'h0, 16'h0003);
        repeat (3) @(negedge clk_sys_in);
        chk("standby analog", 16'h0002, 16'(ana));
        chk("standby drivers", 16'h0000, 16'(fco_oe));
        wreg(4'h0, 16'h0002);
        wait_ready(n);
        chk("standby wake", 16'h0001, 16'(n >= 22 && n <= 30));
        @(posedge clk_sys_in);
        rate_chg <= 1'b1;
        @(posedge clk_sys_in);
        rate_chg <= 1'b0;
        @(negedge clk_sys_in);
        @(negedge clk_sys_in);
        chk("bypass unlocked", 16'h0000, 16'(dcs_active));
        for (n = 2; n < 200 && dcs_active !== 1'b1; n++)
            @(negedge clk_sys_in);
        chk("relock time", 16'h0001, 16'(n >= 60 && n <= 63));
        @(posedge clk_sys_in);
        rate_ok <= 1'b0;
        repeat (3) @(negedge clk_sys_in);
        chk("slow clock", 16'h0000, 16'(dcs_active));
        @(posedge clk_sys_in);
        rate_ok <= 1'b1;
        repeat (70) @(negedge clk_sys_in);
        chk("relocked", 16'h0001, 16'(dcs_active));
        wreg(4'h0, 16'h0000);
        repeat (3) @(negedge clk_sys_in);
        chk("stabilizer off", 16'h0000, 16'(dcs_active));
        @(posedge clk_sys_in);
        strap <= 1'b1;
        do_reset();
        repeat (3) @(posedge clk_sys_in);
        strap <= 1'b0;
        rreg(4'h2, v);
        chk("strap status", 16'h0001, 16'(v[6]));
        chk("strap swing", 16'h0001, 16'(low_swing));
        end_of_test();
    end
endmodule
